//--- inc/bctc_pkg.sv
// Shared constants and types for the bus cycle trace capture block
package bctc_pkg;

    // Trace memory geometry and capture windows
    localparam int          BCTC_MEM_AW    = 15;
    localparam int          BCTC_MEM_DEPTH = 32768;
    localparam logic [15:0] BCTC_FULL_CNT  = 16'h8000;
    localparam logic [15:0] BCTC_HALF_CNT  = 16'h4000;
    localparam int          BCTC_EVT_N     = 6;
    localparam int          BCTC_FIFO_D    = 8;

    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_STAT       = 8'h04;
    localparam logic [7:0]  OFS_RIDX       = 8'h08;
    localparam logic [7:0]  OFS_RLO        = 8'h0c;
    localparam logic [7:0]  OFS_RHI        = 8'h10;
    localparam logic [7:0]  OFS_EVT        = 8'h20;
    localparam logic [7:0]  OFS_EVT_END    = 8'h4c;
    localparam logic [7:0]  OFS_EVT_ACC    = 8'h04;

    // Control register field positions
    localparam int          CTRL_START     = 0;
    localparam int          CTRL_ABORT     = 1;
    localparam int          CTRL_SUSP      = 2;
    localparam int          CTRL_RANGE     = 3;
    localparam int          CTRL_WMODE     = 6;
    localparam int          CTRL_TRIG      = 8;
    localparam int          CTRL_QUAL      = 14;

    // Status register field positions
    localparam int          STAT_STATE     = 0;
    localparam int          STAT_WRAP      = 3;
    localparam int          STAT_SUSP      = 4;
    localparam int          STAT_BUSY      = 5;
    localparam int          STAT_MPTR      = 16;

    // Every control field resets to zero: idle, break range, total write
    localparam logic [31:0] CTRL_RST       = 32'h0000_0000;

    typedef enum logic [2:0] {RNG_BREAK, RNG_BEFORE, RNG_ABOUT, RNG_AFTER, RNG_FULL} bctc_range_e;
    typedef enum logic [1:0] {WM_TOTAL, WM_PICK, WM_EXCL} bctc_wmode_e;
    typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_ARMED, ST_POST, ST_DONE} bctc_state_e;

    // One observed target bus cycle
    typedef struct packed {
        logic [2:0]  acc;
        logic [23:0] addr;
        logic [15:0] data;
    } bctc_cycle_s;

    // One trace event comparator setting
    typedef struct packed {
        logic [23:0] addr;
        logic [2:0]  acc;
    } bctc_evt_s;

endpackage

//--- rtl/bctc_top.sv
// Trace capture logic with its data FIFO and APB register slave
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/10ps
// What this block does
// - In break range the memory keeps the latest 32K cycles up to the target stop.
// - In before range capture freezes at the first trigger, keeping the 32K cycles before it.
// - In about range 16K cycles before the trigger are kept and 16K more are recorded after.
// - In after range recording starts at the trigger and stops after 32K stored cycles.
// - In full range recording starts with tracing and stops after 32K stored cycles.
// - With total write mode every observed cycle is stored.
// - With pick-up write mode only cycles matching the event condition are stored.
// - With exclude write mode only cycles not matching the event condition are stored.
// - Six trace events each compare an access type and an address for equality.
// - The events use the same address and access-type format as breakpoint events.
// - The host may suspend a running measurement and resume it later.

// Small FIFO between capture decision and trace memory
module bctc_fifo #(
    parameter int WIDTH = 43,
    parameter int DEPTH = 8
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             flush,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [PW-1:0] rd;
        logic [PW-1:0] wr;
        logic [CW-1:0] cnt;
        logic          rdy;
    } bctc_fifo_s;

    bctc_fifo_s       f_reg;
    bctc_fifo_s       f_next;
    logic [WIDTH-1:0] store [DEPTH];
    logic             put;
    logic             get;

    // Ready is a flop so the source sees back-pressure without a long path
    assign put       = in_valid && f_reg.rdy;
    assign get       = out_valid && out_ready;
    assign in_ready  = f_reg.rdy;
    assign out_valid = (f_reg.cnt != '0);
    assign out_data  = store[f_reg.rd];

    // Pointer and fill count update
    always_comb
    begin
        f_next = f_reg;
        if (put)
            f_next.wr = (f_reg.wr == PW'(DEPTH - 1)) ? '0 : f_reg.wr + 1'b1;
        if (get)
            f_next.rd = (f_reg.rd == PW'(DEPTH - 1)) ? '0 : f_reg.rd + 1'b1;
        f_next.cnt = f_reg.cnt + CW'(put) - CW'(get);
        f_next.rdy = (f_next.cnt != CW'(DEPTH));
        if (flush)
        begin
            f_next     = '0;
            f_next.rdy = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            f_reg <= '{default: '0, rdy: 1'b1};
        else
            f_reg <= f_next;
    end

    // Data storage needs no reset
    always_ff @(posedge pclk)
    begin
        if (put)
            store[f_reg.wr] <= in_data;
    end
endmodule

module bctc_top (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [31:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  bus_valid,
    input  wire bctc_pkg::bctc_cycle_s bus_cycle,
    output logic                       bus_ready,
    input  wire logic                  target_break
);
    import bctc_pkg::*;

    typedef struct packed {
        bctc_state_e                    st;
        logic                           susp;
        bctc_range_e                    rng;
        bctc_wmode_e                    wm;
        logic [BCTC_EVT_N-1:0]          tmask;
        logic [BCTC_EVT_N-1:0]          qmask;
        bctc_evt_s [BCTC_EVT_N-1:0]     evt;
        logic [BCTC_MEM_AW-1:0]         ridx;
        logic [BCTC_MEM_AW-1:0]         mptr;
        logic                           wrapped;
        logic [15:0]                    left;
        logic                           pready;
        logic                           perr;
        logic [31:0]                    prdata;
    } bctc_regs_s;

    bctc_regs_s             r_reg;
    bctc_regs_s             r_next;
    bctc_cycle_s            mem [BCTC_MEM_DEPTH];
    bctc_cycle_s            drain_data;
    logic                   fifo_rdy;
    logic                   drain_valid;
    logic                   drain_ready;
    logic                   seen;
    logic                   trig;
    logic                   qok;
    logic                   push;
    logic                   post_now;
    logic                   start;
    logic                   wr_acc;
    logic [BCTC_EVT_N-1:0]  hits;
    logic [2:0]             eidx;

    // Address and access equality per event, as breakpoint comparators do
    function automatic logic [BCTC_EVT_N-1:0] evt_hits(input bctc_evt_s [BCTC_EVT_N-1:0] e,
                                                       input bctc_cycle_s c);
        logic [BCTC_EVT_N-1:0] h;
        h = '0;
        for (int i = 0; i < BCTC_EVT_N; i++)
            h[i] = (e[i].addr == c.addr) && (e[i].acc == c.acc);
        return h;
    endfunction

    // Reading the trace data stalls the drain so a word is never read mid-write
    assign drain_ready = !(psel && !penable && (paddr[7:0] == OFS_RLO || paddr[7:0] == OFS_RHI));
    assign wr_acc      = psel && penable && r_reg.pready && pwrite;
    // Start must follow the same address decode as the control write itself
    assign start       = wr_acc && paddr[31:8] == 24'h00_0000 && paddr[7:0] == OFS_CTRL
                         && pwdata[CTRL_START];
    assign eidx        = 3'((paddr[7:0] - OFS_EVT) >> 3);
    assign hits        = evt_hits(r_reg.evt, bus_cycle);
    assign seen        = bus_valid && fifo_rdy && !r_reg.susp;
    assign trig        = |(hits & r_reg.tmask);

    // Write qualifier on the event match
    always_comb
    begin
        unique case (r_reg.wm)
            WM_PICK: qok = |(hits & r_reg.qmask);
            WM_EXCL: qok = !(|(hits & r_reg.qmask));
            default: qok = 1'b1;
        endcase
    end

    // Capture sequencing, drain pointer and register file
    always_comb
    begin
        r_next   = r_reg;
        push     = 1'b0;
        post_now = 1'b0;
        unique case (r_reg.st)
            ST_WAIT:
            begin
                if (seen && trig)
                begin
                    r_next.st   = ST_POST;
                    r_next.left = BCTC_FULL_CNT;
                    post_now    = 1'b1;
                end
            end
            ST_ARMED:
            begin
                unique case (r_reg.rng)
                    RNG_BREAK:
                        if (target_break)
                            r_next.st = ST_DONE;
                        else
                            push = seen && qok;
                    RNG_BEFORE:
                        if (seen && trig)
                            r_next.st = ST_DONE;
                        else
                            push = seen && qok;
                    RNG_ABOUT:
                        if (seen && trig)
                        begin
                            r_next.st   = ST_POST;
                            r_next.left = BCTC_HALF_CNT;
                            post_now    = 1'b1;
                        end
                        else
                            push = seen && qok;
                    default:
                        push = seen && qok;
                endcase
            end
            ST_POST:
                post_now = 1'b1;
            default:
                ;
        endcase
        // Count stored cycles after the trigger
        if (post_now && seen && qok)
        begin
            push        = 1'b1;
            r_next.left = r_next.left - 16'h0001;
            if (r_next.left == 16'h0000)
                r_next.st = ST_DONE;
        end
        // Memory ring pointer follows the drain
        if (drain_valid && drain_ready)
        begin
            r_next.mptr = r_reg.mptr + 1'b1;
            if (r_reg.mptr == BCTC_MEM_AW'(BCTC_MEM_DEPTH - 1))
                r_next.wrapped = 1'b1;
        end
        // APB access phase answer is prepared in the setup cycle
        r_next.pready = psel && !penable;
        r_next.perr   = 1'b0;
        r_next.prdata = 32'h0000_0000;
        if (psel && !penable)
        begin
            if (paddr[31:8] != 24'h00_0000)
                r_next.perr = 1'b1;
            else if (paddr[7:0] == OFS_CTRL)
                r_next.prdata = {12'h000, r_reg.qmask, r_reg.tmask, r_reg.wm, r_reg.rng,
                                 r_reg.susp, 2'b00};
            else if (paddr[7:0] == OFS_STAT)
                r_next.prdata = {1'b0, r_reg.mptr, 10'h000, drain_valid, r_reg.susp,
                                 r_reg.wrapped, r_reg.st};
            else if (paddr[7:0] == OFS_RIDX)
                r_next.prdata = {17'h0_0000, r_reg.ridx};
            else if (paddr[7:0] == OFS_RLO)
                r_next.prdata = {5'h00, mem[r_reg.ridx].acc, mem[r_reg.ridx].addr};
            else if (paddr[7:0] == OFS_RHI)
                r_next.prdata = {16'h0000, mem[r_reg.ridx].data};
            else if (paddr[7:0] >= OFS_EVT && paddr[7:0] <= OFS_EVT_END && paddr[1:0] == 2'b00)
                r_next.prdata = paddr[2] ? {29'h0000_0000, r_reg.evt[eidx].acc}
                                         : {8'h00, r_reg.evt[eidx].addr};
            else
                r_next.perr = 1'b1;
        end
        // Register writes take effect at the access edge
        if (wr_acc && paddr[31:8] == 24'h00_0000)
        begin
            if (paddr[7:0] == OFS_CTRL)
            begin
                r_next.susp  = pwdata[CTRL_SUSP];
                r_next.rng   = (pwdata[CTRL_RANGE+:3] > 3'h4) ? RNG_BREAK
                                                          : bctc_range_e'(pwdata[CTRL_RANGE+:3]);
                r_next.wm    = (pwdata[CTRL_WMODE+:2] == 2'h3) ? WM_TOTAL
                                                           : bctc_wmode_e'(pwdata[CTRL_WMODE+:2]);
                r_next.tmask = pwdata[CTRL_TRIG+:BCTC_EVT_N];
                r_next.qmask = pwdata[CTRL_QUAL+:BCTC_EVT_N];
                if (pwdata[CTRL_ABORT])
                    r_next.st = ST_IDLE;
                if (start)
                begin
                    push           = 1'b0;
                    r_next.mptr    = '0;
                    r_next.wrapped = 1'b0;
                    r_next.left    = BCTC_FULL_CNT;
                    unique case (r_next.rng)
                        RNG_AFTER: r_next.st = ST_WAIT;
                        RNG_FULL:  r_next.st = ST_POST;
                        default:   r_next.st = ST_ARMED;
                    endcase
                end
            end
            else if (paddr[7:0] == OFS_RIDX)
                r_next.ridx = pwdata[BCTC_MEM_AW-1:0];
            else if (paddr[7:0] >= OFS_EVT && paddr[7:0] <= OFS_EVT_END && paddr[1:0] == 2'b00)
            begin
                if (paddr[2])
                    r_next.evt[eidx].acc = pwdata[2:0];
                else
                    r_next.evt[eidx].addr = pwdata[23:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            r_reg <= '0;
        else
            r_reg <= r_next;
    end

    // Trace memory as addressed flip-flops, written from the FIFO output
    always_ff @(posedge pclk)
    begin
        if (drain_valid && drain_ready)
            mem[r_reg.mptr] <= drain_data;
    end

    bctc_fifo #(
        .WIDTH ($bits(bctc_cycle_s)),
        .DEPTH (BCTC_FIFO_D)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .flush     (start),
        .in_valid  (push),
        .in_data   (bus_cycle),
        .in_ready  (fifo_rdy),
        .out_valid (drain_valid),
        .out_data  (drain_data),
        .out_ready (drain_ready)
    );

    assign bus_ready = fifo_rdy;
    assign prdata    = r_reg.prdata;
    assign pready    = r_reg.pready;
    assign pslverr   = r_reg.perr;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_about_trig;
        r_reg.st == ST_ARMED && r_reg.rng == RNG_ABOUT && seen && trig && qok && !wr_acc;
    endsequence
    sequence s_post_half;
        r_reg.st == ST_POST && r_reg.left == BCTC_HALF_CNT - 16'h0001;
    endsequence

    property p_break_stop;
        r_reg.st == ST_ARMED && r_reg.rng == RNG_BREAK && target_break && !wr_acc
        |=> r_reg.st == ST_DONE;
    endproperty
    a_break_stop: assert property (p_break_stop) else $error("break did not stop trace");
    property p_before_freeze;
        r_reg.st == ST_ARMED && r_reg.rng == RNG_BEFORE && seen && trig && !wr_acc
        |-> !push ##1 r_reg.st == ST_DONE;
    endproperty
    a_before_freeze: assert property (p_before_freeze) else $error("before range not frozen");
    property p_about_half;
        s_about_trig |=> s_post_half;
    endproperty
    a_about_half: assert property (p_about_half) else $error("about range count wrong");
    property p_after_start;
        r_reg.st == ST_WAIT && seen && trig && qok && !wr_acc
        |-> push ##1 (r_reg.st == ST_POST && r_reg.left == BCTC_FULL_CNT - 16'h0001);
    endproperty
    a_after_start: assert property (p_after_start) else $error("after range did not start");
    property p_full_start;
        start && pwdata[CTRL_RANGE+:3] == 3'h4 |=> r_reg.st == ST_POST && r_reg.left == BCTC_FULL_CNT;
    endproperty
    a_full_start: assert property (p_full_start) else $error("full range did not start");
    property p_total_all;
        r_reg.st == ST_POST && r_reg.wm == WM_TOTAL && seen && !wr_acc |-> push;
    endproperty
    a_total_all: assert property (p_total_all) else $error("total mode dropped a cycle");
    property p_pick;
        push && r_reg.wm == WM_PICK |-> |(hits & r_reg.qmask);
    endproperty
    a_pick: assert property (p_pick) else $error("pick-up stored a non-match");
    property p_excl;
        push && r_reg.wm == WM_EXCL |-> !(|(hits & r_reg.qmask));
    endproperty
    a_excl: assert property (p_excl) else $error("exclude stored a match");
    property p_susp;
        r_reg.susp |-> !push;
    endproperty
    a_susp: assert property (p_susp) else $error("stored while suspended");
    property p_ring;
        drain_valid && drain_ready && !start && r_reg.mptr == BCTC_MEM_AW'(BCTC_MEM_DEPTH - 1)
        |=> r_reg.mptr == '0 && r_reg.wrapped;
    endproperty
    a_ring: assert property (p_ring) else $error("ring pointer did not wrap");
endmodule

//--- testbench/bctc_bus_src.sv
// Model of the target bus that offers observed cycles to the trace block
`timescale 1ns/10ps
module bctc_bus_src (
    input  wire logic            pclk,
    input  wire logic            presetn,
    input  wire logic            slow,
    input  wire logic [31:0]     lim,
    input  wire logic [23:0]     base,
    input  wire logic            bus_ready,
    output logic                 bus_valid,
    output bctc_pkg::bctc_cycle_s bus_cycle,
    output logic [31:0]          n_taken
);
    import bctc_pkg::*;

    logic [31:0] seq;
    logic        gap;

    // A cycle stays offered until taken; idle data toggles so it is never reused
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_valid <= 1'b0;
            bus_cycle <= '0;
            seq       <= '0;
            n_taken   <= '0;
            gap       <= 1'b0;
        end
        else if (!bus_valid || bus_ready)
        begin
            n_taken <= n_taken + {31'h0, bus_valid};
            gap     <= ~gap;
            // Slow mode leaves a hole every other cycle
            if (seq != lim && !(slow && gap))
            begin
                bus_valid <= 1'b1;
                bus_cycle <= '{acc: 3'h1, addr: base + seq[23:0], data: seq[15:0]};
                seq       <= seq + 32'h1;
            end
            else
            begin
                bus_valid <= 1'b0;
                bus_cycle <= ~bus_cycle;
            end
        end
    end
endmodule

//--- testbench/bctc_top_test.sv
// Self-checking bench for the bus cycle trace capture block
`timescale 1ns/10ps
module bctc_top_test;
    import bctc_pkg::*;

    localparam logic [23:0] BASE = 24'h010000;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        bus_valid;
    bctc_cycle_s bus_cycle;
    logic        bus_ready;
    logic        target_break;
    logic        slow;
    logic [31:0] lim;
    logic [31:0] n_taken;
    logic [31:0] t0;
    logic [31:0] q;
    logic        e;
    int          n_errors;
    int          n_checks;

    bctc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bus_valid(bus_valid), .bus_cycle(bus_cycle),
        .bus_ready(bus_ready), .target_break(target_break));

    bctc_bus_src src_u (.pclk(pclk), .presetn(presetn), .slow(slow), .lim(lim),
        .base(BASE), .bus_ready(bus_ready), .bus_valid(bus_valid), .bus_cycle(bus_cycle),
        .n_taken(n_taken));

    // 25 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic hang();
        n_errors++;
        summarize();
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {24'h0, a};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n >= 20 && pready !== 1'b1)
            hang();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check($sformatf("reg %h", a), q, exp);
    endtask

    task automatic stat(input logic [2:0] st, input logic [14:0] mp);
        apb(1'b0, OFS_STAT, 32'h0);
        check("state", {29'h0, q[2:0]}, {29'h0, st});
        check("mptr", {17'h0, q[30:16]}, {17'h0, mp});
    endtask

    task automatic ev(input int n, input logic [23:0] a, input logic [2:0] acc);
        wr(OFS_EVT + 8'(8 * n), {8'h0, a});
        wr(OFS_EVT + 8'(8 * n) + OFS_EVT_ACC, {29'h0, acc});
    endtask

    // Start a run; t0 is the sequence number of the first offered cycle
    task automatic go(input logic [2:0] r, input logic [1:0] w, input logic [5:0] t,
                      input logic [5:0] qm);
        t0 = lim;
        wr(OFS_CTRL, {12'h0, qm, t, w, r, 3'b001});
    endtask

    // Trace entry idx must hold the cycle offered off places after t0
    task automatic ent(input logic [14:0] idx, input logic [31:0] off);
        wr(OFS_RIDX, {17'h0, idx});
        rd(OFS_RLO, {5'h0, 3'h1, BASE + t0[23:0] + off[23:0]});
        rd(OFS_RHI, {16'h0, t0[15:0] + off[15:0]});
    endtask

    // Offer n cycles, then wait until the FIFO has drained into memory
    task automatic feed(input int n);
        int k;
        lim <= lim + 32'(n);
        @(posedge pclk);
        k = 0;
        while ((n_taken !== lim || bus_valid !== 1'b0) && k < 3 * n + 50)
        begin
            @(posedge pclk);
            k++;
        end
        k = 0;
        do
        begin
            apb(1'b0, OFS_STAT, 32'h0);
            k++;
        end
        while (q[STAT_BUSY] !== 1'b0 && k < 20);
        if (n_taken !== lim || q[STAT_BUSY] !== 1'b0)
            hang();
    endtask

    initial
    begin
        presetn      = 1'b0;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 32'h0;
        pwdata       = 32'h0;
        target_break = 1'b0;
        slow         = 1'b1;
        lim          = 32'h0;
        t0           = 32'h0;
        q            = 32'h0;
        e            = 1'b0;
        n_errors     = 0;
        n_checks     = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Reset values and an unmapped offset
        rd(OFS_CTRL, CTRL_RST);
        stat(ST_IDLE, 15'h0);
        apb(1'b0, 8'h14, 32'h0);
        check("slverr", {31'h0, e}, 32'h1);
        // Six comparators keep address and access type
        for (int i = 0; i < BCTC_EVT_N; i++)
        begin
            ev(i, BASE + 24'(i), 3'(i));
            rd(OFS_EVT + 8'(8 * i), {8'h0, BASE + 24'(i)});
            rd(OFS_EVT + 8'(8 * i) + OFS_EVT_ACC, 32'(i));
        end
        // Pick-up keeps only matches; wrong access type never matches
        ev(1, BASE + lim[23:0] + 24'h5, 3'h1);
        ev(2, BASE + lim[23:0] + 24'h7, 3'h2);
        go(RNG_BREAK, WM_PICK, 6'h0, 6'h06);
        feed(10);
        stat(ST_ARMED, 15'h1);
        ent(15'h0, 32'h5);
        // Exclusion keeps the rest
        ev(1, BASE + lim[23:0] + 24'h5, 3'h1);
        ev(2, BASE + lim[23:0] + 24'h7, 3'h2);
        go(RNG_BREAK, WM_EXCL, 6'h0, 6'h06);
        feed(10);
        stat(ST_ARMED, 15'h9);
        ent(15'h5, 32'h6);
        ent(15'h6, 32'h7);
        // Suspend drops cycles, resume continues
        go(RNG_BREAK, WM_TOTAL, 6'h0, 6'h0);
        feed(10);
        wr(OFS_CTRL, 32'h4);
        apb(1'b0, OFS_STAT, 32'h0);
        check("susp", {31'h0, q[STAT_SUSP]}, 32'h1);
        feed(10);
        stat(ST_ARMED, 15'd10);
        wr(OFS_CTRL, 32'h0);
        feed(10);
        stat(ST_ARMED, 15'd20);
        ent(15'd10, 32'd20);
        // Target stop freezes the break window
        target_break <= 1'b1;
        @(posedge pclk);
        target_break <= 1'b0;
        @(posedge pclk);
        stat(ST_DONE, 15'd20);
        feed(3);
        stat(ST_DONE, 15'd20);
        ent(15'd19, 32'd29);
        slow <= 1'b0;
        // Before range freezes at the trigger, trigger cycle excluded
        ev(0, BASE + lim[23:0] + 24'd20, 3'h1);
        go(RNG_BEFORE, WM_TOTAL, 6'h01, 6'h0);
        feed(30);
        stat(ST_DONE, 15'd20);
        ent(15'd19, 32'd19);
        // After range waits, then records from the trigger
        ev(0, BASE + lim[23:0] + 24'd50, 3'h1);
        go(RNG_AFTER, WM_TOTAL, 6'h01, 6'h0);
        feed(40);
        stat(ST_WAIT, 15'd0);
        feed(40);
        stat(ST_POST, 15'd30);
        ent(15'd0, 32'd50);
        // About range: ring wraps, 16K kept on each side of the trigger
        ev(0, BASE + lim[23:0] + 24'd20000, 3'h1);
        go(RNG_ABOUT, WM_TOTAL, 6'h01, 6'h0);
        feed(36389);
        stat(ST_DONE, 15'd3616);
        check("wrap", {31'h0, q[STAT_WRAP]}, 32'h1);
        ent(15'd3616, 32'd3616);
        ent(15'd3615, 32'd36383);
        // Full range stops after a whole memory
        go(RNG_FULL, WM_TOTAL, 6'h0, 6'h0);
        feed(32772);
        stat(ST_DONE, 15'd0);
        ent(15'd32767, 32'd32767);
        ent(15'd0, 32'd0);
        // Abort returns to idle; out-of-range range and write codes fall back to defaults
        wr(OFS_CTRL, {12'h0, 6'h2a, 6'h15, 2'h3, 3'h7, 3'b110});
        rd(OFS_CTRL, {12'h0, 6'h2a, 6'h15, 2'h0, 3'h0, 1'b1, 2'b00});
        stat(ST_IDLE, 15'd0);
        summarize();
    end
endmodule
